// ---- dv/aux_pins_model.sv ----
// board side of the aux port: pull-ups, outside drivers, highway clocks
// assumes core_clk at 125 MHz; every aux line and the interrupt line pulled up
`timescale 1ns/1ps
module aux_pins_model (
  input wire logic core_clk,
  input wire logic [7:0] aux_out,
  input wire logic [7:0] aux_oe,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_lvl,
  input wire logic int_out,
  input wire logic int_oe,
  output logic [7:0] aux_in,
  output logic int_pin,
  output logic highway_data_clock,
  output logic frame_sync,
  output logic s_clock_1536
);
  logic [11:0] cnt = 12'h000;
  always @(posedge core_clk) cnt <= (cnt == 12'h8FF) ? 12'h000 : cnt + 12'h001;
  assign highway_data_clock = (cnt % 12'h00C) < 12'h006;
  // rises on a clock fall, so clear and toggle never collide
  assign frame_sync = cnt >= 12'h006 && cnt < 12'h012;
  assign s_clock_1536 = cnt[3];
  // released lines float high
  assign aux_in = (aux_oe & aux_out) | (~aux_oe & ~ext_en) | (~aux_oe & ext_en & ext_lvl);
  assign int_pin = int_oe ? int_out : 1'h1;
endmodule : aux_pins_model

// ---- dv/aux_port_and_bit_clock_assertions.sv ----
// port assertions of the aux port block
// assumes highway clocks far slower than core_clk, as the pin model makes them
`timescale 1ns/1ps
module aux_port_checker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [7:0] aux_in,
  input wire logic [7:0] aux_oe,
  input wire logic mode_pin_0,
  input wire logic mode_pin_1,
  input wire logic highway_data_clock,
  input wire logic s_clock_1536,
  input wire logic [2:0] channel_select,
  input wire logic bit_clock_out,
  input wire logic int_out,
  input wire logic int_oe,
  input wire logic irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer wrong");
  a_rdata_holds: assert property (!(hsel && htrans[1] && !hwrite) |=> $stable(hrdata))
    else $error("read data moved");
  a_int_driven: assert property (irq |-> int_oe)
    else $error("interrupt pin not driven");
  a_int_quiet: assert property (!irq |-> !int_out)
    else $error("interrupt pin active idle");
  a_chan_follows: assert property ((mode_pin_0 && $stable(aux_in[2:0]))[*5] |->
    channel_select == aux_in[2:0]) else $error("channel select wrong");
  a_chan_inputs: assert property (mode_pin_0 [*4] |-> aux_oe[2:0] == 3'h0)
    else $error("channel pins driven");
  a_bclk_div: assert property ((!(mode_pin_0 && !mode_pin_1))[*8] ##0
    $rose(highway_data_clock) |-> ##[2:6] $changed(bit_clock_out)) else $error("bit clock late");
  a_ltt_clock: assert property ((mode_pin_0 && !mode_pin_1)[*8] ##0
    $rose(s_clock_1536) |-> ##[2:6] $rose(bit_clock_out)) else $error("s clock not forwarded");
  cover property ($rose(irq));
  cover property (mode_pin_0 && channel_select == 3'h7);
  cover property (mode_pin_0 && !mode_pin_1 && $rose(bit_clock_out));
endmodule : aux_port_checker
bind aux_port_and_bit_clock aux_port_checker aux_port_checker_i (.*);

// ---- dv/test_aux_port_and_bit_clock.sv ----
// self-checking bench of the aux port block over ahb-lite
// assumes the pin model supplies pull-ups and highway clocks
`timescale 1ns/1ps
module test_aux_port_and_bit_clock import aux_port_pkg::*;;
  logic core_clk = 1'h0, rst_n = 1'h0, hsel = 1'h0, hwrite = 1'h0, rd_ph = 1'h0, dd = 1'h0;
  logic mode_pin_0 = 1'h0, mode_pin_1 = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, r, hrdata;
  logic [7:0] ext_en = 8'h00, ext_lvl = 8'hFF, aux_in, aux_out, aux_oe;
  logic [2:0] channel_select;
  logic hreadyout, hresp, multiframe_bit, bit_clock_out, int_out, int_oe, irq, int_pin;
  logic highway_data_clock, frame_sync, s_clock_1536;
  logic [31:0] exp_q[$];
  int error_cnt = 0, n_checks = 0;
  integer seed = 32'h3993D52F;
  always #4 core_clk = ~core_clk;
  aux_port_and_bit_clock aux_port_and_bit_clock_i (.core_clk, .rst_n, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .aux_in,
    .aux_out, .aux_oe, .mode_pin_0, .mode_pin_1, .frame_sync, .highway_data_clock,
    .downstream_data(dd), .s_clock_1536, .channel_select, .multiframe_bit, .bit_clock_out,
    .int_out, .int_oe, .irq);
  aux_pins_model aux_pins_model_i (.core_clk, .aux_out, .aux_oe, .ext_en, .ext_lvl, .int_out,
    .int_oe, .aux_in, .int_pin, .highway_data_clock, .frame_sync, .s_clock_1536);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  // on a read, d is the expected word
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge core_clk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph <= !w;
    if (!w) exp_q.push_back(d);
    do @(posedge core_clk); while (hreadyout !== 1'h1);
    rd_ph <= 1'h0;
  endtask : bus
  task summarize;
    if (error_cnt == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  always @(posedge core_clk) begin
    if (rd_ph && hreadyout === 1'h1 && exp_q.size() > 0)
      check(hrdata, exp_q.pop_front());
  end
  initial begin
    #320000;
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'h1;
    @(posedge core_clk);
    bus(1'h0, OFS_DIR, {24'h0, RST_DIR});
    bus(1'h0, OFS_OUT, {24'h0, RST_OUT});
    bus(1'h0, OFS_OPEN_DRAIN, {24'h0, RST_OPEN_DRAIN});
    bus(1'h1, 8'h3C, 32'hFFFFFFFF);
    bus(1'h0, 8'h3C, 32'h0);
    r = $random(seed);
    ext_en <= 8'hF0;
    ext_lvl <= r[15:8];
    bus(1'h1, OFS_OPEN_DRAIN, 32'h0);
    bus(1'h1, OFS_OUT, r);
    bus(1'h1, OFS_DIR, 32'h0F);
    bus(1'h1, OFS_SG_POS, {29'h0, r[18:16]});
    repeat (5) @(posedge core_clk);
    bus(1'h0, OFS_IN, {24'h0, r[15:12], r[3:0]});
    bus(1'h0, OFS_SG_POS, {29'h0, r[18:16]});
    bus(1'h1, OFS_DIR, 32'h0);
    ext_en <= 8'hFF;
    ext_lvl <= 8'hFF;
    repeat (4) @(posedge core_clk);
    bus(1'h1, OFS_IRQ_CLEAR, 32'h3);
    bus(1'h1, OFS_IRQ_ENABLE, 32'h1);
    ext_lvl <= 8'h3F;
    repeat (6) @(posedge core_clk);
    bus(1'h0, OFS_IRQ_STATUS, 32'h3);
    check({31'h0, int_pin}, 32'h0);
    // edge mode: a pin held low must not set again; pin 7 masked
    bus(1'h1, OFS_IRQ_CLEAR, 32'h1);
    repeat (3) @(posedge core_clk);
    bus(1'h0, OFS_IRQ_STATUS, 32'h2);
    check({31'h0, irq}, 32'h0);
    bus(1'h1, OFS_IRQ_LEVEL, 32'h1);
    repeat (3) @(posedge core_clk);
    bus(1'h0, OFS_IRQ_STATUS, 32'h3);
    bus(1'h1, OFS_CFG, 32'h10);
    repeat (3) @(posedge core_clk);
    check({31'h0, int_pin}, 32'h1);
    ext_lvl <= 8'hFF;
    bus(1'h1, OFS_IRQ_LEVEL, 32'h0);
    bus(1'h1, OFS_IRQ_CLEAR, 32'h3);
    repeat (3) @(posedge core_clk);
    check({30'h0, irq, int_pin}, 32'h0);
    bus(1'h1, OFS_DIR, 32'h07);
    mode_pin_0 <= 1'h1;
    mode_pin_1 <= 1'h1;
    for (int i = 0; i < 8; i++) begin
      ext_lvl <= {5'h1F, i[2:0]};
      repeat (6) @(posedge core_clk);
      check({29'h0, channel_select}, {29'h0, i[2:0]});
    end
    bus(1'h1, OFS_CFG, 32'h01);
    for (int v = 0; v < 2; v++) begin
      ext_lvl <= {3'h7, v[0], 4'hF};
      repeat (6) @(posedge core_clk);
      check({31'h0, multiframe_bit}, {31'h0, v[0]});
    end
    bus(1'h0, OFS_MODE_STATUS, 32'h3F);
    mode_pin_0 <= 1'h0;
    for (int v = 0; v < 2; v++) begin
      bus(1'h1, OFS_CFG, {26'h0, v[0], 5'h01});
      repeat (4) @(posedge core_clk);
      check({31'h0, aux_in[4]}, {31'h0, v[0]});
    end
    bus(1'h1, OFS_CFG, 32'h02);
    @(posedge frame_sync);
    repeat (8) @(posedge core_clk);
    check({31'h0, aux_in[5]}, 32'h1);
    bus(1'h1, OFS_CFG, 32'h06);
    @(posedge bit_clock_out);
    repeat (4) @(posedge core_clk);
    check({31'h0, aux_in[5]}, 32'h1);
    repeat (12) @(posedge core_clk);
    check({31'h0, aux_in[5]}, 32'h0);
    bus(1'h1, OFS_CFG, 32'h08);
    for (int v = 0; v < 2; v++) begin
      dd <= v[0];
      repeat (2) @(posedge frame_sync);
      repeat (8) @(posedge core_clk);
      check({31'h0, aux_in[7]}, {31'h0, v[0]});
    end
    mode_pin_0 <= 1'h1;
    mode_pin_1 <= 1'h0;
    repeat (200) @(posedge core_clk);
    summarize();
  end
endmodule : test_aux_port_and_bit_clock

// ---- hdl/aux_port_and_bit_clock.sv ----
// auxiliary port, interrupt pin and bit clock generation behind an ahb-lite slave
// assumes highway clock, frame sync and data are slow against core_clk and sampled
//
// The AHB-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module aux_port_and_bit_clock
  import aux_port_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [7:0] aux_in,
  output logic [7:0] aux_out,
  output logic [7:0] aux_oe,
  input wire logic mode_pin_0,
  input wire logic mode_pin_1,
  input wire logic frame_sync,
  input wire logic highway_data_clock,
  input wire logic downstream_data,
  input wire logic s_clock_1536,
  output logic [2:0] channel_select,
  output logic multiframe_bit,
  output logic bit_clock_out,
  output logic int_out,
  output logic int_oe,
  output logic irq
);

  logic [7:0] aux_meta_q;
  logic [7:0] aux_sync_q;
  logic [7:0] aux_prev_q;
  logic [2:0] clk_meta_q;
  logic [2:0] clk_sync_q;
  logic dcl_prev_q;
  logic fsc_prev_q;
  logic mode_pin_0_q;
  logic mode_pin_1_q;
  op_mode_t mode;
  bus_req_t req_q;
  logic [7:0] dir_q;
  logic [7:0] out_q;
  logic [7:0] od_q;
  logic [CFG_WIDTH-1:0] cfg_q;
  logic [1:0] irq_status_q;
  logic [1:0] irq_enable_q;
  logic [1:0] irq_level_q;
  logic [7:0] sg_pos_q;
  logic [31:0] hrdata_q;
  logic bclk_q;
  logic [8:0] dcl_cnt_q;
  logic sg_bit_q;
  logic [2:0] chan_q;
  logic multiframe_bit_in_q;
  logic int_level_q;
  logic int_pp_q;
  logic dcl_rise;
  logic fsc_rise;
  logic wr_en;
  logic [1:0] irq_set;
  logic [1:0] irq_clr;
  logic [31:0] rdata;
  logic [31:0] rdata_fwd;
  pin_drive_t drive;
  logic [7:0] aux_out_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aux_meta_q <= 8'hFF;
      aux_sync_q <= 8'hFF;
      aux_prev_q <= 8'hFF;
    end else begin
      aux_meta_q <= aux_in;
      aux_sync_q <= aux_meta_q;
      aux_prev_q <= aux_sync_q;
    end
  end

  // highway clock, frame sync and s clock arrive unrelated to core_clk
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_meta_q <= 3'h0;
      clk_sync_q <= 3'h0;
      dcl_prev_q <= 1'b0;
      fsc_prev_q <= 1'b0;
    end else begin
      clk_meta_q <= {s_clock_1536, frame_sync, highway_data_clock};
      clk_sync_q <= clk_meta_q;
      dcl_prev_q <= clk_sync_q[0];
      fsc_prev_q <= clk_sync_q[1];
    end
  end

  assign dcl_rise = clk_sync_q[0] & ~dcl_prev_q;
  assign fsc_rise = clk_sync_q[1] & ~fsc_prev_q;

  // mode straps, sampled every cycle after release
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_pin_0_q <= 1'b0;
      mode_pin_1_q <= 1'b0;
    end else begin
      mode_pin_0_q <= mode_pin_0;
      mode_pin_1_q <= mode_pin_1;
    end
  end

  always_comb begin
    case ({mode_pin_0_q, mode_pin_1_q})
      2'b10: mode = LINE_TERM_T_MODE;
      2'b11: mode = LINE_TERM_S_MODE;
      default: mode = TERMINAL_MODE;
    endcase
  end

  // ahb-lite slave: address phase captured, always zero wait, always okay
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_q <= '0;
    end else if (hready) begin
      req_q.sel <= hsel & htrans[1];
      req_q.addr <= haddr[7:0];
      req_q.write <= hwrite;
    end
  end

  assign wr_en = req_q.sel & req_q.write;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_q <= RST_DIR;
      out_q <= RST_OUT;
      od_q <= RST_OPEN_DRAIN;
      cfg_q <= RST_CFG;
      sg_pos_q <= RST_SG_POS;
      irq_enable_q <= RST_IRQ;
      irq_level_q <= RST_IRQ;
    end else if (wr_en) begin
      case (req_q.addr)
        OFS_DIR: dir_q <= hwdata[7:0];
        OFS_OUT: out_q <= hwdata[7:0];
        OFS_OPEN_DRAIN: od_q <= hwdata[7:0];
        OFS_CFG: cfg_q <= hwdata[CFG_WIDTH-1:0];
        OFS_SG_POS: sg_pos_q <= hwdata[7:0];
        OFS_IRQ_ENABLE: irq_enable_q <= hwdata[1:0];
        OFS_IRQ_LEVEL: irq_level_q <= hwdata[1:0];
        default: ;
      endcase
    end
  end

  // falling edge or low level on pins 6 and 7, only while inputs
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (irq_level_q[i]) begin
        irq_set[i] = ~dir_q[PIN_IRQ0+i] & ~aux_sync_q[PIN_IRQ0+i];
      end else begin
        irq_set[i] = ~dir_q[PIN_IRQ0+i] & aux_prev_q[PIN_IRQ0+i] & ~aux_sync_q[PIN_IRQ0+i];
      end
    end
  end

  assign irq_clr = (wr_en && req_q.addr == OFS_IRQ_CLEAR) ? hwdata[1:0] : 2'h0;

  // set beats a clear landing in the same cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_q <= RST_IRQ;
    end else begin
      irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
    end
  end

  // mask gates status onto the request
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_level_q <= 1'b0;
      int_pp_q <= 1'b0;
    end else begin
      int_level_q <= |(irq_status_q & irq_enable_q);
      int_pp_q <= cfg_q[CFG_INT_PUSH_PULL];
    end
  end

  assign irq = int_level_q;

  // open-drain low by default, push-pull high when chosen
  assign int_out = int_pp_q ? int_level_q : 1'b0;
  assign int_oe = int_pp_q ? 1'b1 : int_level_q;

  // divide highway clock by two, aligned to frame start
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bclk_q <= 1'b0;
    end else if (fsc_rise) begin
      bclk_q <= 1'b0;
    end else if (dcl_rise) begin
      bclk_q <= ~bclk_q;
    end
  end

  // frame sync restarts the highway clock count each frame
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dcl_cnt_q <= 9'h000;
    end else if (fsc_rise) begin
      dcl_cnt_q <= 9'h000;
    end else if (dcl_rise) begin
      dcl_cnt_q <= dcl_cnt_q + 9'h001;
    end
  end

  // s/g bit sampled mid-bit from downstream data at chosen slot
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sg_bit_q <= 1'b0;
    end else if (dcl_rise && dcl_cnt_q == {sg_pos_q, 1'b1}) begin
      sg_bit_q <= downstream_data;
    end
  end

  // line-termination-t passes the s-interface clock out
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_clock_out <= 1'b0;
    end else if (mode == LINE_TERM_T_MODE) begin
      bit_clock_out <= clk_sync_q[2];
    end else begin
      bit_clock_out <= bclk_q;
    end
  end

  // channel select taken from pins 0-2 outside terminal mode
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_q <= 3'h0;
      multiframe_bit_in_q <= 1'b0;
    end else begin
      if (mode != TERMINAL_MODE) begin
        chan_q <= aux_sync_q[2:0];
      end
      if (cfg_q[CFG_MULTIFRAME_BIT_SEL] && mode == LINE_TERM_S_MODE) begin
        multiframe_bit_in_q <= aux_sync_q[PIN_MULTIFRAME_BIT];
      end
    end
  end

  assign channel_select = chan_q;
  assign multiframe_bit = multiframe_bit_in_q;

  // pin function multiplexing
  always_comb begin
    drive.level = out_q;
    drive.enable = dir_q;
    // pins 0-2 gpio only in terminal mode
    if (mode != TERMINAL_MODE) begin
      drive.enable[2:0] = 3'h0;
    end
    if (cfg_q[CFG_MULTIFRAME_BIT_SEL]) begin
      drive.level[PIN_MULTIFRAME_BIT] = cfg_q[CFG_MULTIFRAME_BIT_TX];
      drive.enable[PIN_MULTIFRAME_BIT] = (mode != LINE_TERM_S_MODE);
    end
    // frame sync or bit clock onto pin 5
    if (cfg_q[CFG_FB_SEL]) begin
      drive.level[PIN_FB] = cfg_q[CFG_FB_CHOICE] ? bclk_q : clk_sync_q[1];
      drive.enable[PIN_FB] = 1'b1;
    end
    // s/g bit replaces gpio on pin 7
    if (cfg_q[CFG_SGO_EN]) begin
      drive.level[PIN_SGO] = sg_bit_q;
      drive.enable[PIN_SGO] = 1'b1;
    end
  end

  // outputs registered; open-drain pins only pull low
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aux_out_q <= 8'h00;
      aux_oe <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        aux_out_q[i] <= od_q[i] ? 1'b0 : drive.level[i];
        aux_oe[i] <= od_q[i] ? (drive.enable[i] & ~drive.level[i]) : drive.enable[i];
      end
    end
  end

  assign aux_out = aux_out_q;

  // read mux; status and input reads show live block state
  always_comb begin
    rdata = 32'h0000_0000;
    case (haddr[7:0])
      OFS_DIR: rdata[7:0] = dir_q;
      OFS_OUT: rdata[7:0] = out_q;
      OFS_IN: rdata[7:0] = aux_sync_q;
      OFS_CFG: rdata[CFG_WIDTH-1:0] = cfg_q;
      // status as it stands after this edge, so a clear just before is seen
      OFS_IRQ_STATUS: rdata[1:0] = (irq_status_q & ~irq_clr) | irq_set;
      OFS_IRQ_ENABLE: rdata[1:0] = irq_enable_q;
      OFS_IRQ_LEVEL: rdata[1:0] = irq_level_q;
      OFS_OPEN_DRAIN: rdata[7:0] = od_q;
      OFS_MODE_STATUS: rdata[7:0] = {2'h0, multiframe_bit_in_q, chan_q, mode};
      OFS_SG_POS: rdata[7:0] = sg_pos_q;
      default: rdata = 32'h0000_0000;
    endcase
  end

  // a write in its data phase lands on the edge that takes a read right behind it;
  // its data is passed through so that read does not return the stale word
  always_comb begin
    rdata_fwd = rdata;
    if (wr_en && req_q.addr == haddr[7:0]) begin
      case (req_q.addr)
        OFS_DIR, OFS_OUT, OFS_OPEN_DRAIN, OFS_SG_POS: rdata_fwd = {24'h00_0000, hwdata[7:0]};
        OFS_CFG: rdata_fwd = {{(32-CFG_WIDTH){1'b0}}, hwdata[CFG_WIDTH-1:0]};
        OFS_IRQ_ENABLE, OFS_IRQ_LEVEL: rdata_fwd = {30'h0, hwdata[1:0]};
        default: ;
      endcase
    end
  end

  // read data latched at address phase so it stands through the data phase
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_q <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata_q <= rdata_fwd;
    end
  end

  assign hrdata = hrdata_q;

endmodule : aux_port_and_bit_clock

// ---- pkg/aux_port_pkg.sv ----
// constants, register map and carrier types of the auxiliary port block
// assumes a single core clock and an ahb-lite master with word accesses
// What this block does
// - terminal mode: pins 0-2 each software input or output, read and written
// - line or network termination: pins 0-2 inputs forming three-bit channel select
// - pin 3 general input or output, level readable, output from register
// - multiframe select set: pin 4 carries multiframe bit, direction set by mode
// - frame/bitclock select set: pin 5 drives frame sync or bit clock by choice
// - pins 6 and 7 as inputs raise maskable edge or level interrupts
// - pins 6 and 7 general inputs or outputs when alternates unused
// - alternate function drives pin 7 with s/g bit from downstream data
// - terminal mode: bit clock is highway data clock divided by two
// - line-termination-t mode: bit clock pin carries 1.536 mhz s-interface clock
// - network or line-termination-s: bit clock is data clock divided by two
// - frame sync 8 khz marks frames; data clock runs at twice bit rate
// - interrupt pin open-drain active low by default, optionally push-pull high
package aux_port_pkg;

  localparam logic [7:0] OFS_DIR = 8'h00;
  localparam logic [7:0] OFS_OUT = 8'h04;
  localparam logic [7:0] OFS_IN = 8'h08;
  localparam logic [7:0] OFS_CFG = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h14;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h18;
  localparam logic [7:0] OFS_IRQ_LEVEL = 8'h1C;
  localparam logic [7:0] OFS_OPEN_DRAIN = 8'h20;
  localparam logic [7:0] OFS_MODE_STATUS = 8'h24;
  localparam logic [7:0] OFS_SG_POS = 8'h28;

  localparam logic [7:0] RST_DIR = 8'h00;
  localparam logic [7:0] RST_OUT = 8'hFF;
  localparam logic [7:0] RST_OPEN_DRAIN = 8'hFF;
  localparam logic [7:0] RST_SG_POS = 8'h00;
  localparam logic [1:0] RST_IRQ = 2'h0;

  // cfg register field positions
  localparam int CFG_MULTIFRAME_BIT_SEL = 0;
  localparam int CFG_FB_SEL = 1;
  localparam int CFG_FB_CHOICE = 2;
  localparam int CFG_SGO_EN = 3;
  localparam int CFG_INT_PUSH_PULL = 4;
  localparam int CFG_MULTIFRAME_BIT_TX = 5;
  localparam int CFG_WIDTH = 6;
  localparam logic [CFG_WIDTH-1:0] RST_CFG = 6'h00;

  // bit positions on the aux port
  localparam int PIN_MULTIFRAME_BIT = 4;
  localparam int PIN_FB = 5;
  localparam int PIN_IRQ0 = 6;
  localparam int PIN_SGO = 7;

  typedef enum logic [1:0] {
    TERMINAL_MODE = 2'b00,
    LINE_TERM_T_MODE = 2'b01,
    LINE_TERM_S_MODE = 2'b11
  } op_mode_t;

  typedef struct packed {
    logic [7:0] level;
    logic [7:0] enable;
  } pin_drive_t;

  typedef struct packed {
    logic sel;
    logic [7:0] addr;
    logic write;
  } bus_req_t;

endpackage : aux_port_pkg
